// File: verilog/eth_irq_pkg.sv
// shared constants and types for the ethernet interrupt flag block
package eth_irq_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] base_offset    = 8'h00;  // flags register, plain write
    localparam logic [7:0] clear_offset   = 8'h04;  // clear alias
    localparam logic [7:0] set_offset     = 8'h08;  // set alias
    localparam logic [7:0] invert_offset  = 8'h0c;  // invert alias
    localparam logic [7:0] enable_offset  = 8'h10;  // interrupt enable (mask)
    localparam logic [7:0] received_buffer_counter_offset  = 8'h20;  // received buffer counter view
    localparam logic [7:0] decrement_offset = 8'h24; // counter decrement control

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int overflow_bit    = 0;
    localparam int unavailable_bit = 1;
    localparam int abort_bit       = 2;
    localparam int done_bit        = 3;
    localparam int activity_bit    = 5;
    localparam int pending_bit     = 6;
    localparam int flag_width      = 7;
    localparam int count_width     = 8;

    // bits that software and the event strobes may change directly
    localparam logic [6:0] sticky_mask  = 7'h2f;
    localparam logic [6:0] flags_reset  = 7'h00;
    localparam logic [6:0] enable_reset = 7'h00;
    localparam logic [7:0] count_reset  = 8'h00;
    localparam logic [31:0] read_zero   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        op_write,
        op_clear,
        op_set,
        op_invert
    } flag_op_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        write;
        logic        read;
    } bus_req_type;

    typedef struct packed {
        logic rx_stored;      // packet data written into receive buffer fifo
        logic tx_done;        // status vector written back
        logic tx_abort;       // mac aborted a packet
        logic rx_desc_overrun;
        logic rx_fifo_overflow;
        logic rx_packet_done; // one more packet in memory
    } event_type;

endpackage

// File: verilog/flag_alias_unit.sv
// one sticky flag with set-wins-over-clear and alias update
`timescale 1ns/10ps
module flag_alias_unit (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst,
    // software access
    input  wire logic                     sw_hit,
    input  wire eth_irq_pkg::flag_op_type sw_op,
    input  wire logic                     sw_bit,
    // hardware event
    input  wire logic                     hw_event,
    // state
    output logic                          flag
);

    logic next_flag;

    // software effect first, the hardware event then overrides it
    always_comb begin
        next_flag = flag;
        if (sw_hit) begin
            case (sw_op)
                eth_irq_pkg::op_write:  next_flag = sw_bit;
                eth_irq_pkg::op_clear:  next_flag = flag & ~sw_bit;
                eth_irq_pkg::op_set:    next_flag = flag | sw_bit;
                default:                next_flag = flag ^ sw_bit;
            endcase
        end
        if (hw_event) begin
            next_flag = 1'b1;   // an event in the clearing cycle is never lost
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

endmodule // flag_alias_unit

// File: verilog/ethernet_irq_flags.sv
// interrupt request flag register of the ethernet controller
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/10ps
module ethernet_irq_flags (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic [31:0]            reg_rdata,
    // internal event strobes from mac and receive buffer manager
    input  wire eth_irq_pkg::event_type events,
    // flag and interrupt outputs
    output logic [6:0]             ethernet_interrupt_request_flags,
    output logic                   irq
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    eth_irq_pkg::bus_req_type     req;
    eth_irq_pkg::flag_op_type     flag_op;
    wire logic                    flag_addr;
    wire logic                    flag_hit;
    wire logic                    enable_wr;
    wire logic                    decrement_wr;
    wire logic                    received_buffer_counter_rd;

    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.write = reg_write;
    assign req.read  = reg_read;

    // one match for the flag word and its aliases, shared by write decode and read mux
    function automatic logic is_flag_addr(input logic [7:0] a);
        return a == eth_irq_pkg::base_offset
            || a == eth_irq_pkg::clear_offset
            || a == eth_irq_pkg::set_offset
            || a == eth_irq_pkg::invert_offset;
    endfunction

    // the four aliases share one flag array and differ only in the operation
    assign flag_addr = is_flag_addr(req.addr);
    assign flag_hit  = req.write && flag_addr;
    always_comb begin
        if (req.addr == eth_irq_pkg::clear_offset) begin
            flag_op = eth_irq_pkg::op_clear;
        end else if (req.addr == eth_irq_pkg::set_offset) begin
            flag_op = eth_irq_pkg::op_set;
        end else if (req.addr == eth_irq_pkg::invert_offset) begin
            flag_op = eth_irq_pkg::op_invert;
        end else begin
            flag_op = eth_irq_pkg::op_write;
        end
    end
    assign enable_wr    = req.write && req.addr == eth_irq_pkg::enable_offset;
    assign decrement_wr = req.write && req.addr == eth_irq_pkg::decrement_offset;
    assign received_buffer_counter_rd    = req.read && req.addr == eth_irq_pkg::received_buffer_counter_offset;

    // ------------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------------
    logic [6:0] sticky;
    logic [6:0] hw_set;

    // unused positions carry no event; bit 4 and bit 6 are never sticky
    always_comb begin
        hw_set = 7'h00;
        hw_set[eth_irq_pkg::activity_bit]    = events.rx_stored;
        hw_set[eth_irq_pkg::done_bit]        = events.tx_done;
        hw_set[eth_irq_pkg::abort_bit]       = events.tx_abort;
        hw_set[eth_irq_pkg::unavailable_bit] = events.rx_desc_overrun;
        hw_set[eth_irq_pkg::overflow_bit]    = events.rx_fifo_overflow;
    end

    genvar i;
    generate
        for (i = 0; i < eth_irq_pkg::flag_width; i = i + 1) begin : g_flag
            if (eth_irq_pkg::sticky_mask[i]) begin : g_sticky
                flag_alias_unit u_flag (
                    .mclk     (mclk),
                    .rst      (rst),
                    .sw_hit   (flag_hit),
                    .sw_op    (flag_op),
                    .sw_bit   (req.wdata[i]),
                    .hw_event (hw_set[i]),
                    .flag     (sticky[i])
                );
            end else begin : g_none
                assign sticky[i] = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // received buffer counter
    // ------------------------------------------------------------------
    logic [7:0] received_buffer_counter;
    logic [7:0] next_count;
    wire logic  buffer_count_decrement;
    wire logic  count_up;
    wire logic  count_down;

    // a bit-0 write of one to the decrement control is the decrement
    assign buffer_count_decrement = decrement_wr && req.wdata[0];
    // saturate rather than wrap, a wrapped counter would fake a pending packet
    assign count_up   = events.rx_packet_done && received_buffer_counter != 8'hff;
    assign count_down = buffer_count_decrement && received_buffer_counter != 8'h00;

    always_comb begin
        next_count = received_buffer_counter;
        if (count_up && !count_down) begin
            next_count = received_buffer_counter + 8'h01;
        end else if (count_down && !count_up) begin
            next_count = received_buffer_counter - 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            received_buffer_counter <= eth_irq_pkg::count_reset;
        end else begin
            received_buffer_counter <= next_count;
        end
    end

    // pending ignores every flag alias write, it only mirrors the counter
    wire logic packet_pending_flag;
    assign packet_pending_flag = |received_buffer_counter;

    // ------------------------------------------------------------------
    // enable and interrupt
    // ------------------------------------------------------------------
    logic [6:0] enable;
    wire logic [6:0] all_flags;

    always_ff @(posedge mclk) begin
        if (rst) begin
            enable <= eth_irq_pkg::enable_reset;
        end else if (enable_wr) begin
            enable <= req.wdata[6:0] & ~7'h10;
        end
    end

    assign all_flags = {packet_pending_flag, sticky[5:0]};

    // registered outputs lag the flag state by one cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            ethernet_interrupt_request_flags <= eth_irq_pkg::flags_reset;
            irq                              <= 1'b0;
        end else begin
            ethernet_interrupt_request_flags <= all_flags;
            irq                              <= |(all_flags & enable);
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [31:0] next_rdata;

    // aliases read back the flag word; unmapped addresses read zero
    always_comb begin
        next_rdata = eth_irq_pkg::read_zero;
        if (req.read) begin
            if (flag_addr) begin
                next_rdata[6:0] = all_flags;
            end else if (req.addr == eth_irq_pkg::enable_offset) begin
                next_rdata[6:0] = enable;
            end else if (received_buffer_counter_rd) begin
                next_rdata[7:0] = received_buffer_counter;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= eth_irq_pkg::read_zero;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // ethernet_irq_flags

// File: test/ethernet_irq_flags_props.sv
// concurrent checks on the ports of the ethernet interrupt flag block
`timescale 1ns/10ps
module ethernet_irq_flags_props (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    input  wire logic [31:0]            reg_rdata,
    // events and outputs
    input  wire eth_irq_pkg::event_type events,
    input  wire logic [6:0]             ethernet_interrupt_request_flags,
    input  wire logic                   irq
);
    // short alias keeps the property lines readable
    wire logic [6:0] fw = ethernet_interrupt_request_flags;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // event to flag
    // ------------------------------------------------------------------
    // the flag word is registered, so a strobe shows two edges later
    sequence shown_s(logic fl);
        ##2 fl;
    endsequence
    property set_p(logic ev, logic fl);
        ev |-> shown_s(fl);
    endproperty
    activity_set_a: assert property (set_p(events.rx_stored, fw[5]))
        else $error("activity flag not set");
    done_set_a: assert property (set_p(events.tx_done, fw[3]))
        else $error("done flag not set");
    abort_set_a: assert property (set_p(events.tx_abort, fw[2]))
        else $error("abort flag not set");
    unavail_set_a: assert property (set_p(events.rx_desc_overrun, fw[1]))
        else $error("unavailable flag not set");
    overflow_set_a: assert property (set_p(events.rx_fifo_overflow, fw[0]))
        else $error("overflow flag not set");

    // ------------------------------------------------------------------
    // holding, pending and request
    // ------------------------------------------------------------------
    // a sticky flag may only drop after a write that is not the set alias
    sticky_fall_a: assert property (|(~fw & $past(fw) & eth_irq_pkg::sticky_mask)
        |-> $past(reg_write, 2) && $past(reg_addr, 2) != eth_irq_pkg::set_offset)
        else $error("sticky flag dropped without write");
    pending_rise_a: assert property (events.rx_packet_done |-> ##[2:3] fw[6])
        else $error("pending flag not raised");
    pending_fall_a: assert property ($fell(fw[6]) |->
        ($past(reg_write, 2) && $past(reg_addr, 2) == eth_irq_pkg::decrement_offset) ||
        ($past(reg_write, 3) && $past(reg_addr, 3) == eth_irq_pkg::decrement_offset))
        else $error("pending flag dropped without decrement");
    pending_keep_a: assert property (reg_write && reg_addr != eth_irq_pkg::decrement_offset
        && !events.rx_packet_done |-> ##2 $stable(fw[6]))
        else $error("pending flag moved by a flag write");
    irq_cause_a: assert property (irq |-> fw != 7'h00)
        else $error("request without flag");
    bit4_zero_a: assert property (!fw[4])
        else $error("unimplemented flag bit set");
    read_word_a: assert property ($past(reg_read) &&
        $past(reg_addr) == eth_irq_pkg::base_offset |-> reg_rdata[31:7] == 25'h0 && !reg_rdata[4])
        else $error("reserved read bits set");
endmodule // ethernet_irq_flags_props

bind ethernet_irq_flags ethernet_irq_flags_props u_props (
    .mclk                            (mclk),
    .rst                             (rst),
    .reg_addr                        (reg_addr),
    .reg_wdata                       (reg_wdata),
    .reg_write                       (reg_write),
    .reg_read                        (reg_read),
    .reg_rdata                       (reg_rdata),
    .events                          (events),
    .ethernet_interrupt_request_flags(ethernet_interrupt_request_flags),
    .irq                             (irq)
);

// File: test/tb_ethernet_irq_flags.sv
// self-checking bench for the ethernet interrupt flag block
`timescale 1ns/10ps
module tb_ethernet_irq_flags;
    logic                   mclk = 1'b0;
    logic                   rst = 1'b1;
    logic [7:0]             reg_addr = 8'h00;
    logic [31:0]            reg_wdata = 32'h0000_0000;
    logic                   reg_write = 1'b0;
    logic                   reg_read = 1'b0;
    logic [31:0]            reg_rdata;
    eth_irq_pkg::event_type events = '0;
    logic [6:0]             flags;
    logic                   irq;
    logic [6:0]             sticky;
    logic [6:0]             en;
    logic [7:0]             cnt;
    logic [31:0]            d;
    logic [31:0]            r;
    logic [31:0]            v;
    int                     n_fail = 0;
    int                     n_compared = 0;
    int                     seed = 32'h0000_3038;

    ethernet_irq_flags uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .events(events),
        .ethernet_interrupt_request_flags(flags), .irq(irq));

    always #4 mclk = ~mclk;

    // ------------------------------------------------------------------
    // model and bus tasks
    // ------------------------------------------------------------------
    // base, clear, set and invert effect on the sticky flags
    function automatic logic [6:0] apply_op(input logic [1:0] op, input logic [6:0] f,
                                            input logic [6:0] w);
        case (op)
            2'h0: return w & eth_irq_pkg::sticky_mask;
            2'h1: return f & ~w;
            2'h2: return f | (w & eth_irq_pkg::sticky_mask);
            default: return f ^ (w & eth_irq_pkg::sticky_mask);
        endcase
    endfunction
    function automatic logic [31:0] word();
        return {25'h0, cnt != 8'h00, sticky[5:0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= w;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic pulse(input eth_irq_pkg::event_type e);
        @(posedge mclk);
        events <= e;
        @(posedge mclk);
        events <= '0;
        sticky = sticky | {1'b0, e.rx_stored, 1'b0, e.tx_done, e.tx_abort,
                           e.rx_desc_overrun, e.rx_fifo_overflow};
        if (e.rx_packet_done && cnt != 8'hff) cnt = cnt + 8'h01;
    endtask
    task automatic check_all();
        rd(eth_irq_pkg::base_offset);
        chk(d, word());
        rd(eth_irq_pkg::received_buffer_counter_offset);
        chk(d, {24'h0, cnt});
        rd(eth_irq_pkg::enable_offset);
        chk(d, {25'h0, en});
        rd(8'h3c);
        chk(d, 32'h0000_0000);
        chk({25'h0, flags}, word());
        chk({31'h0, irq}, {31'h0, |(word() & {25'h0, en})});
    endtask
    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // sequence of tests
    // ------------------------------------------------------------------
    // watchdog sized well above the roughly four thousand cycles of the run
    initial begin
        repeat (30000) @(posedge mclk);
        n_fail++;
        stop_test();
    end

    initial begin
        sticky = 7'h00;
        en = 7'h00;
        cnt = 8'h00;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        check_all();
        // random aliases, events, decrements and unmapped writes
        for (int k = 0; k < 200; k++) begin
            r = $random(seed);
            v = $random(seed);
            wr(eth_irq_pkg::enable_offset, r);
            en = r[6:0] & 7'h6f;
            pulse(eth_irq_pkg::event_type'(r[13:8]));
            if (!r[18]) begin
                wr({4'h0, r[17:16], 2'h0}, v);
                sticky = apply_op(r[17:16], sticky, v[6:0]);
            end else if (r[19]) begin
                wr(eth_irq_pkg::decrement_offset, 32'h0000_0001);
                if (cnt != 8'h00) cnt = cnt - 8'h01;
            end else begin
                wr(8'h3c, v);
            end
            check_all();
        end
        // clear and every sticky-flag event (not rx_packet_done) in the same cycle: setting wins
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr  <= eth_irq_pkg::clear_offset;
        reg_wdata <= 32'h0000_002f;
        events    <= eth_irq_pkg::event_type'(6'h3e);
        @(posedge mclk);
        reg_write <= 1'b0;
        events    <= '0;
        sticky = 7'h2f;
        check_all();
        // counter saturates at the top and stops at zero
        repeat (260) pulse(eth_irq_pkg::event_type'(6'h01));
        check_all();
        repeat (256) wr(eth_irq_pkg::decrement_offset, 32'h0000_0001);
        cnt = 8'h00;
        check_all();
        // reset in mid-run clears everything
        pulse(eth_irq_pkg::event_type'(6'h3f));
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        sticky = 7'h00;
        en = 7'h00;
        cnt = 8'h00;
        check_all();
        stop_test();
    end
endmodule // tb_ethernet_irq_flags
